// ### hw/scl_loader.sv
// Serial configuration loader: shifts setup bits in on serial clock edges
// and hands the chain on through the done output and data pass-through.
// Assumes the serial clock is much slower than sys_clk (edges found by sampling).
// Notes on behaviour
// (RQ1) Serial mode chosen at reset uses serial clock.
// (RQ2) Capture data on rising clock while enable low.
// (RQ3) All chained devices share one serial clock.
// (RQ4) Downstream enable driven by upstream done output.
// (RQ5) Drive done low when own load finishes.
// (RQ6) After programming, done follows load enable.
// (RQ7) Controller drives first device's load enable.
// (RQ8) Loaded device passes data in to out.
// (RQ9) Low done means ready for normal operation.
// (RQ10) Setup registers are bit-serial shift registers.
// (RQ11) Done stays high until own load completes.
`timescale 1ns/1ps
`default_nettype none
module scl_loader
   import scl_pkg::*;
(
   input  wire logic                  sys_clk,
   input  wire logic                  rst_b,
   input  wire logic                  serial_mode,
   input  wire logic                  serial_clk,
   input  wire logic                  serial_data_in,
   input  wire logic                  serial_load_enable_in_n,
   output var  logic                  chain_done_out_n,
   output var  logic                  serial_data_out,
   output var  logic                  device_ready,
   output var  logic [SETUP_BITS-1:0] setup_data
);

   // -----------------------------------------------------------------
   // Pin sampling
   // -----------------------------------------------------------------
   scl_link_t link_raw;
   scl_link_t link;

   assign link_raw = '{sclk: serial_clk, sdata: serial_data_in,
                       load_n: serial_load_enable_in_n};

   scl_sync u_sync
   (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .din     (link_raw),
      .dout    (link)
   );

   // -----------------------------------------------------------------
   // Mode strap, caught after reset release
   // -----------------------------------------------------------------
   logic mode_caught;
   logic serial_sel;
   logic next_mode_caught;
   logic next_serial_sel;
   logic mode_meta;
   logic mode_sync;
   logic next_mode_meta;
   logic next_mode_sync;

   // The strap is a pin, so it passes two flops before it is caught.
   // These flops stay out of reset so the level held during reset has
   // already settled when the first edge after release catches it.
   always_comb
   begin
      next_mode_meta = serial_mode;
      next_mode_sync = mode_meta;
   end

   always_ff @(posedge sys_clk)
   begin
      mode_meta <= next_mode_meta;
      mode_sync <= next_mode_sync;
   end

   always_comb
   begin
      next_mode_caught = 1'b1;
      next_serial_sel  = mode_caught ? serial_sel : mode_sync;
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mode_caught <= 1'b0;
         serial_sel  <= 1'b0;
      end
      else
      begin
         mode_caught <= next_mode_caught;
         serial_sel  <= next_serial_sel;
      end
   end

   // -----------------------------------------------------------------
   // Loader state and shift register
   // -----------------------------------------------------------------
   scl_state_t              state;
   scl_state_t              next_state;
   logic                    sclk_prev;
   logic                    next_sclk_prev;
   logic                    sclk_rise;
   logic [CNT_W-1:0]        count;
   logic [CNT_W-1:0]        next_count;
   logic [SETUP_BITS-1:0]   next_setup_data;
   logic                    next_done_n;
   logic                    next_sdo;

   assign sclk_rise = link.sclk && !sclk_prev;

   always_comb
   begin
      next_state      = state;
      next_count      = count;
      next_setup_data = setup_data;
      next_sclk_prev  = link.sclk;
      unique case (state)
         SCL_IDLE:
         begin
            // Without serial mode the default setup is taken as loaded.
            if (mode_caught)
            begin
               next_state = serial_sel ? SCL_LOAD : SCL_DONE;
            end
         end
         SCL_LOAD:
         begin
            // (RQ1) (RQ2) (RQ10) shift on gated rising edge
            if (sclk_rise && !link.load_n)
            begin
               next_setup_data = {setup_data[SETUP_BITS-2:0], link.sdata};
               next_count      = count + 6'h01;
               if (count == CNT_LAST)
               begin
                  next_state = SCL_DONE;
               end
            end
         end
         SCL_DONE:
         begin
            next_state = SCL_DONE;
         end
      endcase
   end

   // (RQ5) (RQ6) (RQ11) done high until loaded, then follows enable
   always_comb
   begin
      next_done_n = (next_state == SCL_DONE) ? link.load_n : 1'b1;
   end

   // (RQ8) pass data through once loaded and done low
   always_comb
   begin
      next_sdo = (next_state == SCL_DONE && !next_done_n) ? link.sdata : 1'b0;
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state            <= SCL_IDLE;
         count            <= CNT_ZERO;
         setup_data       <= SETUP_RESET;
         sclk_prev        <= 1'b0;
         chain_done_out_n <= 1'b1;
         serial_data_out  <= 1'b0;
      end
      else
      begin
         state            <= next_state;
         count            <= next_count;
         setup_data       <= next_setup_data;
         sclk_prev        <= next_sclk_prev;
         chain_done_out_n <= next_done_n;
         serial_data_out  <= next_sdo;
      end
   end

   // (RQ9) ready flag mirrors a low done output
   assign device_ready = !chain_done_out_n;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   sequence s_gated_rise;
      state == SCL_LOAD && sclk_rise && !link.load_n;
   endsequence

   a_shift_captures_bit: assert property // (RQ2)
      (s_gated_rise |=> setup_data[0] == $past(link.sdata))
      else $error("Setup bit not captured on gated rise.");

   a_no_shift_disabled: assert property // (RQ2)
      (state == SCL_LOAD && link.load_n |=> $stable(setup_data))
      else $error("Setup changed while load disabled.");

   a_count_advances: assert property // (RQ10)
      (s_gated_rise |=> count == $past(count) + 6'h01)
      else $error("Bit counter did not advance.");

   a_done_high_loading: assert property // (RQ11)
      (state != SCL_DONE |-> chain_done_out_n)
      else $error("Done low before load complete.");

   a_done_goes_low: assert property // (RQ5)
      (s_gated_rise ##0 (count == CNT_LAST) |=> !chain_done_out_n)
      else $error("Done not low after final bit.");

   a_done_tracks_en: assert property // (RQ6)
      (state == SCL_DONE |=> chain_done_out_n == $past(link.load_n))
      else $error("Done does not follow load enable.");

   a_pass_through: assert property // (RQ8)
      (state == SCL_DONE && !link.load_n |=> serial_data_out == $past(link.sdata))
      else $error("Serial data not passed through.");

   a_serial_mode_load: assert property // (RQ1)
      (mode_caught && serial_sel && state == SCL_IDLE |=> state == SCL_LOAD)
      else $error("Serial mode did not enter loading.");

   a_ready_matches: assert property // (RQ9)
      (device_ready |-> state == SCL_DONE)
      else $error("Ready before programming finished.");

endmodule
`default_nettype wire

// ### hw/scl_pkg.sv
// Package for the serial configuration chain loader.
// Assumes a single system clock domain; link pins are sampled into it.
package scl_pkg;

   // -----------------------------------------------------------------
   // Setup register layout
   // -----------------------------------------------------------------
   localparam int unsigned SETUP_BITS = 32;
   localparam int unsigned CNT_W      = 6;
   localparam logic [CNT_W-1:0] CNT_LAST = 6'h1f;
   localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
   localparam logic [SETUP_BITS-1:0] SETUP_RESET = 32'h0000_0000;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      SCL_IDLE = 3'b001,
      SCL_LOAD = 3'b010,
      SCL_DONE = 3'b100
   } scl_state_t;

   typedef struct packed
   {
      logic sclk;
      logic sdata;
      logic load_n;
   } scl_link_t;

endpackage

// ### hw/scl_sync.sv
// Two-flop synchroniser for a bundle of link pins.
// Assumes the inputs are asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module scl_sync
   import scl_pkg::*;
(
   input  wire logic      sys_clk,
   input  wire logic      rst_b,
   input  wire scl_link_t din,
   output var  scl_link_t dout
);

   scl_link_t stage1;
   scl_link_t next_stage1;
   scl_link_t next_dout;

   // Load enable idles high so an unconnected chain does not start loading.
   always_comb
   begin
      next_stage1 = din;
      next_dout   = stage1;
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stage1 <= '{sclk: 1'b0, sdata: 1'b0, load_n: 1'b1};
         dout   <= '{sclk: 1'b0, sdata: 1'b0, load_n: 1'b1};
      end
      else
      begin
         stage1 <= next_stage1;
         dout   <= next_dout;
      end
   end

endmodule
`default_nettype wire

// ### tb/scl_ctrl_model.sv
// Behavioural model of the configuration controller that feeds the chain.
// Assumes the bench calls its tasks; the pins are asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module scl_ctrl_model
(
   output var logic sclk,
   output var logic sdata,
   output var logic load_n
);
   initial
   begin
      sclk = 1'b0;
      sdata = 1'b0;
      load_n = 1'b1;
   end

   task set_load(input logic v);
      load_n <= v;
   endtask

   // Sends the low n bits of w, highest bit first, at a 48 ns clock period.
   // The clock stands low outside frames and released data is inverted.
   task send(input logic [31:0] w, input int n);
      for (int i = n - 1; i >= 0; i--)
      begin
         sdata <= w[i];
         #24;
         sclk <= 1'b1;
         #24;
         sclk <= 1'b0;
      end
      // Holding the released level a while keeps a following call from
      // assigning the data pin twice in one time step.
      sdata <= ~sdata;
      #24;
   endtask
endmodule
`default_nettype wire

// ### tb/serial_config_chain_loader_tb_top.sv
// Testbench for two chained loaders fed by one controller model.
// Assumes a three-edge pin latency inside each loader.
`timescale 1ns/1ps
`default_nettype none
module serial_config_chain_loader_tb_top;
   import scl_pkg::*;
   localparam logic [31:0] W1 = 32'hc3a5_5a3c;
   localparam logic [31:0] W2 = 32'h1e2d_f00f;
   logic                  sys_clk = 1'b0;
   logic                  rst_b = 1'b0;
   logic                  serial_mode = 1'b1;
   logic                  sclk, sdata, load_n;
   logic                  done1_n, sdo1, rdy1, done2_n, rdy2;
   logic [SETUP_BITS-1:0] set1, set2;
   int                    mismatches = 0;
   int                    checks = 0;

   always #2.5 sys_clk = ~sys_clk;

   scl_ctrl_model i_ctrl (.sclk(sclk), .sdata(sdata), .load_n(load_n));

   scl_loader i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .serial_mode(serial_mode),
      .serial_clk(sclk), .serial_data_in(sdata), .serial_load_enable_in_n(load_n),
      .chain_done_out_n(done1_n), .serial_data_out(sdo1), .device_ready(rdy1),
      .setup_data(set1));
   scl_loader i_dut_next (.sys_clk(sys_clk), .rst_b(rst_b), .serial_mode(serial_mode),
      .serial_clk(sclk), .serial_data_in(sdo1), .serial_load_enable_in_n(done1_n),
      .chain_done_out_n(done2_n), .serial_data_out(), .device_ready(rdy2),
      .setup_data(set2));

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task report_and_stop;
      if (mismatches == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Waits a bounded time for a done output to reach a level.
   task wait_done(input logic nxt, input logic lvl);
      int n;
      n = 0;
      while (((nxt ? done2_n : done1_n) !== lvl) && n < 100)
      begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 100)
      begin
         mismatches++;
         report_and_stop();
      end
   endtask

   task do_reset(input logic mode);
      @(posedge sys_clk);
      rst_b <= 1'b0;
      serial_mode <= mode;
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge sys_clk);
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task t_enable_high;
      check("done after reset", done1_n, 1'b1);
      check("ready after reset", rdy1, 1'b0);
      check("pass data before load", sdo1, 1'b0);
      i_ctrl.send(32'h0000_000a, 4);
      repeat (8) @(posedge sys_clk);
      check("setup with enable high", set1, 32'h0000_0000);
      check("done with enable high", done1_n, 1'b1);
   endtask

   task t_first_load;
      i_ctrl.set_load(1'b0);
      i_ctrl.send(W1 >> 1, 31);
      repeat (8) @(posedge sys_clk);
      check("done one bit short", done1_n, 1'b1);
      check("setup one bit short", set1, W1 >> 1);
      i_ctrl.send(W1, 1);
      wait_done(1'b0, 1'b0);
      check("setup full", set1, W1);
      check("ready when done", rdy1, 1'b1);
      check("next still unloaded", done2_n, 1'b1);
   endtask

   task t_pass_through;
      i_ctrl.send(W2, 32);
      wait_done(1'b1, 1'b0);
      check("next setup", set2, W2);
      check("first setup kept", set1, W1);
      check("next ready", rdy2, 1'b1);
   endtask

   task t_track_enable;
      i_ctrl.set_load(1'b1);
      wait_done(1'b0, 1'b1);
      wait_done(1'b1, 1'b1);
      check("ready follows enable", rdy1, 1'b0);
      i_ctrl.set_load(1'b0);
      wait_done(1'b1, 1'b0);
      check("setup after tracking", set1, W1);
   endtask

   task t_default_mode;
      do_reset(1'b0);
      i_ctrl.send(W1, 8);
      repeat (8) @(posedge sys_clk);
      check("default mode done", done1_n, 1'b0);
      check("default mode setup", set1, 32'h0000_0000);
   endtask

   initial
   begin
      do_reset(1'b1);
      t_enable_high();
      t_first_load();
      t_pass_through();
      t_track_enable();
      t_default_mode();
      report_and_stop();
   end
endmodule
`default_nettype wire
